/* File: verilog/spi_master_regs.svh */
// Register map, field positions, reset values and timing counts of the SPI master.
// Overview of operation
// - Config bits 6:4 divide core clock by 2,4,8,16,32; codes 5-7 divide by 64.
// - Config bit 3 set sends and receives LSB first, clear sends MSB first.
// - Config bit 2 set makes serial clock active low; clear makes it active high.
// - Config bit 1 set: sample trailing, shift leading; clear: sample leading, shift trailing.
// - Config bit 0 clear freezes the master core; set lets it run.
// - While enabled and the RX FIFO is not full, writing the data port starts a transfer.
// - Data port write pushes a two-entry TX FIFO; read pops a two-entry RX FIFO.
// - Status bit 3 reads 1 while the RX FIFO is full.
// - Status bit 2 reads 1 while the RX FIFO holds at least one byte.
// - Status bit 1 shows TX empty, bit 0 TX space; both reset to 1.
// - Status flags follow present FIFO state and clear themselves.
// - Mask bits 3:0 gate the four status sources; all reset to masked.
// - Configuration register resets to 0x20.
// - The master drives no chip-select output.
// - Full duplex: one byte received for each byte sent.
`ifndef SPI_MASTER_REGS_SVH
`define SPI_MASTER_REGS_SVH

`define CFG_ADDR 8'hFC
`define MASK_ADDR 8'hFD
`define STATUS_ADDR 8'hFE
`define DATA_ADDR 8'hFF

`define CFG_RESET 7'h20
`define MASK_RESET 4'hF
`define DATA_EMPTY_VALUE 8'h00

`define CFG_DIV_HI 6
`define CFG_DIV_LO 4
`define CFG_LSB_BIT 3
`define CFG_CPOL_BIT 2
`define CFG_CPHA_BIT 1
`define CFG_ON_BIT 0

`define ST_RX_FULL 3
`define ST_RX_AVAIL 2
`define ST_TX_EMPTY 1
`define ST_TX_SPACE 0

`define HALF_DIV2 6'h00
`define HALF_DIV4 6'h01
`define HALF_DIV8 6'h03
`define HALF_DIV16 6'h07
`define HALF_DIV32 6'h0F
`define HALF_DIV64 6'h1F

`define FIRST_EDGE 4'h0
`define LAST_EDGE 4'hF
`define FIFO_DEPTH 2'h2

`endif

/* File: verilog/spi_master_pkg.sv */
// Types shared by the SPI master files.
package spi_master_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_SHIFT = 3'b100
    } xfer_state_t;

endpackage : spi_master_pkg

/* File: verilog/spi_byte_fifo.sv */
// Two-entry byte FIFO built from flip-flops.
`include "spi_master_regs.svh"

module spi_byte_fifo (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic push,
    input wire spi_master_pkg::byte_t pushData,
    input wire logic pop,
    output spi_master_pkg::byte_t popData,
    output logic full,
    output logic empty
);
    import spi_master_pkg::*;

    byte_t mem_ff [0:1];
    logic wrPtr_ff;
    logic rdPtr_ff;
    logic [1:0] count_ff;
    logic doPush;
    logic doPop;

    assign full = (count_ff == `FIFO_DEPTH);
    assign empty = (count_ff == 2'h0);
    assign doPush = push && !full;
    assign doPop = pop && !empty;
    assign popData = mem_ff[rdPtr_ff];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_ff[0] <= 8'h00;
            mem_ff[1] <= 8'h00;
            wrPtr_ff <= 1'b0;
        end else if (doPush) begin
            mem_ff[wrPtr_ff] <= pushData;
            wrPtr_ff <= ~wrPtr_ff;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdPtr_ff <= 1'b0;
        end else if (doPop) begin
            rdPtr_ff <= ~rdPtr_ff;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_ff <= 2'h0;
        end else begin
            case ({doPush, doPop})
                2'b10: count_ff <= count_ff + 2'h1;
                2'b01: count_ff <= count_ff - 2'h1;
                default: count_ff <= count_ff;
            endcase
        end
    end

endmodule : spi_byte_fifo

/* File: verilog/spi_master_fifo.sv */
// SPI master with register port, two-byte FIFOs and serial shift engine.
`include "spi_master_regs.svh"

module spi_master_fifo (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire spi_master_pkg::byte_t sfrWdata,
    output spi_master_pkg::byte_t sfrRdata,
    output logic irqRequest,
    output logic master_serial_clock_pin,
    output logic master_out_pin,
    input wire logic master_in_pin
);
    import spi_master_pkg::*;

    // Half-period length minus one, in core clock cycles.
    function automatic logic [5:0] halfPeriod(input logic [2:0] code);
        logic [5:0] r;
        r = `HALF_DIV64;
        case (code)
            3'h0: r = `HALF_DIV2;
            3'h1: r = `HALF_DIV4;
            3'h2: r = `HALF_DIV8;
            3'h3: r = `HALF_DIV16;
            3'h4: r = `HALF_DIV32;
            default: r = `HALF_DIV64;
        endcase
        return r;
    endfunction : halfPeriod

    function automatic logic outBit(input byte_t sh, input logic lsbFirst);
        return lsbFirst ? sh[0] : sh[7];
    endfunction : outBit

    // Drops the bit just sent and takes the sampled bit in at the far end.
    function automatic byte_t shiftIn(input byte_t sh, input logic b, input logic lsbFirst);
        return lsbFirst ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shiftIn

    // Address decode shared by the register writes and the FIFO strobes; the read mux decodes in its own case.
    function automatic logic regHit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : regHit

    logic [6:0] config_ff;
    logic [3:0] irqMask_ff;
    byte_t rdata_ff;
    logic irq_ff;
    logic sck_ff;
    logic mosi_ff;
    logic misoMeta_ff;
    logic misoSync_ff;
    xfer_state_t state_ff;
    logic [3:0] edgeCnt_ff;
    logic [5:0] divCnt_ff;
    byte_t shift_ff;
    logic sampleBit_ff;

    logic masterOn;
    logic lsbFirst;
    logic cpol;
    logic cpha;
    logic [2:0] divCode;
    logic tick;
    logic edgeTick;
    logic startOk;
    logic txPush;
    logic txPop;
    logic rxPush;
    logic rxPop;
    logic sampleEdge;
    logic shiftEdge;
    byte_t rxByte;
    byte_t txHead;
    byte_t rxHead;
    logic txFull;
    logic txEmpty;
    logic rxFull;
    logic rxEmpty;
    logic [3:0] status;
    byte_t nxt_shift;

    assign masterOn = config_ff[`CFG_ON_BIT];
    assign lsbFirst = config_ff[`CFG_LSB_BIT];
    assign cpol = config_ff[`CFG_CPOL_BIT];
    assign cpha = config_ff[`CFG_CPHA_BIT];
    assign divCode = config_ff[`CFG_DIV_HI:`CFG_DIV_LO];

    assign sfrRdata = rdata_ff;
    assign irqRequest = irq_ff;
    assign master_serial_clock_pin = sck_ff;
    assign master_out_pin = mosi_ff;

    // Register port: writes of config, mask and data port, reads of all four registers; status ignores writes.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            config_ff <= `CFG_RESET;
        end else if (sfrWrite && regHit(sfrAddr, `CFG_ADDR)) begin
            config_ff <= sfrWdata[6:0];
        end
    end

    // Every source starts masked, so no request leaves before software opens one.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irqMask_ff <= `MASK_RESET;
        end else if (sfrWrite && regHit(sfrAddr, `MASK_ADDR)) begin
            irqMask_ff <= sfrWdata[3:0];
        end
    end

    // A data write while the TX FIFO is full is dropped inside the FIFO.
    assign txPush = sfrWrite && regHit(sfrAddr, `DATA_ADDR);
    // Reading an empty RX FIFO returns zero and moves no pointer.
    assign rxPop = sfrRead && regHit(sfrAddr, `DATA_ADDR) && !rxEmpty;

    // Status bits are plain views of the FIFO levels, never latched.
    always_comb begin
        status = 4'h0;
        status[`ST_RX_FULL] = rxFull;
        status[`ST_RX_AVAIL] = !rxEmpty;
        status[`ST_TX_EMPTY] = txEmpty;
        status[`ST_TX_SPACE] = !txFull;
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (sfrRead) begin
            case (sfrAddr)
                `CFG_ADDR: rdata_ff <= {1'b0, config_ff};
                `MASK_ADDR: rdata_ff <= {4'h0, irqMask_ff};
                `STATUS_ADDR: rdata_ff <= {4'h0, status};
                `DATA_ADDR: rdata_ff <= rxEmpty ? `DATA_EMPTY_VALUE : rxHead;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    // The request comes from a flop, so it lags the status and mask by one cycle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status & ~irqMask_ff);
        end
    end

    // Transmit side: filled by data port writes, drained as each byte starts.
    spi_byte_fifo txFifo (
        .core_clk(core_clk),
        .reset(reset),
        .push(txPush),
        .pushData(sfrWdata),
        .pop(txPop),
        .popData(txHead),
        .full(txFull),
        .empty(txEmpty)
    );

    // Receive side: filled as each byte ends, drained by data port reads.
    spi_byte_fifo rxFifo (
        .core_clk(core_clk),
        .reset(reset),
        .push(rxPush),
        .pushData(rxByte),
        .pop(rxPop),
        .popData(rxHead),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // The input pin comes from another chip and is synchronised first.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            misoMeta_ff <= 1'b0;
        end else begin
            misoMeta_ff <= master_in_pin;
        end
    end

    // Only this second stage is read by the engine.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            misoSync_ff <= 1'b0;
        end else begin
            misoSync_ff <= misoMeta_ff;
        end
    end

    // Half-period divider; it only runs while a byte is on the wire and the core is on.
    assign tick = masterOn && (state_ff != ST_IDLE) && (divCnt_ff == 6'h00);
    // One serial clock edge is due in this cycle.
    assign edgeTick = (state_ff == ST_SHIFT) && tick;

    // The divider reloads while idle so every byte starts with a full half period.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            divCnt_ff <= `HALF_DIV8;
        end else if (state_ff == ST_IDLE || tick) begin
            divCnt_ff <= halfPeriod(divCode);
        end else if (masterOn) begin
            divCnt_ff <= divCnt_ff - 6'h01;
        end
    end

    // A byte starts only with the core on, TX data waiting and room to keep the reply.
    assign startOk = masterOn && !txEmpty && !rxFull;
    assign txPop = (state_ff == ST_IDLE) && startOk;

    // Even edge counts are leading edges, odd ones trailing edges.
    assign sampleEdge = (edgeCnt_ff[0] == cpha);
    assign shiftEdge = cpha ? (!edgeCnt_ff[0] && edgeCnt_ff != `FIRST_EDGE)
                            : (edgeCnt_ff[0] && edgeCnt_ff != `LAST_EDGE);
    assign nxt_shift = shiftIn(shift_ff, sampleBit_ff, lsbFirst);

    // The final bit is the live sample for trailing-edge sampling, else the held one.
    assign rxByte = shiftIn(shift_ff, cpha ? misoSync_ff : sampleBit_ff, lsbFirst);
    assign rxPush = edgeTick && (edgeCnt_ff == `LAST_EDGE);

    // Shift engine; no chip select is produced, software drives its own pins.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (startOk) begin
                        state_ff <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick && edgeCnt_ff == `LAST_EDGE) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Counts serial clock edges within a byte; it restarts whenever the engine is idle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            edgeCnt_ff <= `FIRST_EDGE;
        end else if (state_ff == ST_IDLE) begin
            edgeCnt_ff <= `FIRST_EDGE;
        end else if (edgeTick) begin
            edgeCnt_ff <= edgeCnt_ff + 4'h1;
        end
    end

    // The shift register is loaded as a byte starts and moves on each shift edge.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            shift_ff <= 8'h00;
        end else if (txPop) begin
            shift_ff <= txHead;
        end else if (edgeTick && shiftEdge) begin
            shift_ff <= nxt_shift;
        end
    end

    // The first bit goes out as the byte is taken, so it is settled before any edge.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mosi_ff <= 1'b0;
        end else if (txPop) begin
            mosi_ff <= outBit(txHead, lsbFirst);
        end else if (edgeTick && shiftEdge) begin
            mosi_ff <= outBit(nxt_shift, lsbFirst);
        end
    end

    // The synchroniser delays the input by two core cycles. At the two fastest rates
    // a slave that changes its bit on the shift edge is therefore sampled a bit late.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sampleBit_ff <= 1'b0;
        end else if (edgeTick && sampleEdge) begin
            sampleBit_ff <= misoSync_ff;
        end
    end

    // Serial clock rests at the polarity level outside bytes and toggles on each edge.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sck_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            sck_ff <= cpol;
        end else if (edgeTick) begin
            sck_ff <= ~sck_ff;
        end
    end

endmodule : spi_master_fifo

/* File: dv/spi_master_fifo_properties.sv */
// Checker bound to the SPI master ports.
`include "spi_master_regs.svh"
module spi_master_fifo_properties (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire spi_master_pkg::byte_t sfrWdata,
    input wire spi_master_pkg::byte_t sfrRdata,
    input wire logic irqRequest,
    input wire logic master_serial_clock_pin,
    input wire logic master_out_pin,
    input wire logic master_in_pin
);
    import spi_master_pkg::*;
    logic [6:0] cfg_ff;
    logic [3:0] mask_ff;
    logic [7:0] gap_ff;
    logic [7:0] half;
    wire logic sck = master_serial_clock_pin;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    assign half = (cfg_ff[6:4] > 3'h4) ? 8'h20 : (8'h01 << cfg_ff[6:4]);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_ff <= `CFG_RESET;
            mask_ff <= `MASK_RESET;
        end else if (sfrWrite && sfrAddr == `CFG_ADDR) begin
            cfg_ff <= sfrWdata[6:0];
        end else if (sfrWrite && sfrAddr == `MASK_ADDR) begin
            mask_ff <= sfrWdata[3:0];
        end
    end
    // Counts cycles since the serial clock last moved.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            gap_ff <= 8'hFF;
        end else if ($changed(sck)) begin
            gap_ff <= 8'h01;
        end else if (gap_ff != 8'hFF) begin
            gap_ff <= gap_ff + 8'h01;
        end
    end
    a_cfg_read: assert property (sfrRead && sfrAddr == `CFG_ADDR |=>
        sfrRdata == {1'b0, $past(cfg_ff)}) else $error("config read wrong");
    a_mask_read: assert property (sfrRead && sfrAddr == `MASK_ADDR |=>
        sfrRdata == {4'h0, $past(mask_ff)}) else $error("mask read wrong");
    a_unmapped_zero: assert property (sfrRead && sfrAddr < `CFG_ADDR |=>
        sfrRdata == 8'h00) else $error("unmapped read not zero");
    a_status_upper: assert property (sfrRead && sfrAddr == `STATUS_ADDR |=>
        sfrRdata[7:4] == 4'h0) else $error("status upper bits set");
    a_engine_frozen: assert property (!cfg_ff[0] && $stable(cfg_ff) |=>
        $stable(sck) && $stable(master_out_pin)) else $error("pins moved while off");
    a_sck_gap: assert property ($changed(sck) && cfg_ff[0] && $stable(cfg_ff)
        && cfg_ff == $past(cfg_ff, 2) |-> gap_ff >= half) else $error("half period short");
    a_irq_masked: assert property (mask_ff == 4'hF && $past(mask_ff) == 4'hF |->
        !irqRequest) else $error("irq while all masked");
    a_empty_pop: assert property ((sfrRead && sfrAddr == `STATUS_ADDR && !cfg_ff[0])
        ##2 (sfrRead && sfrAddr == `DATA_ADDR && !sfrRdata[`ST_RX_AVAIL]) |=>
        sfrRdata == 8'h00) else $error("empty pop not zero");
    c_irq: cover property (irqRequest);
    c_sck: cover property ($changed(sck) && cfg_ff[0]);
    c_pop: cover property (sfrRead && sfrAddr == `DATA_ADDR);
endmodule : spi_master_fifo_properties

bind spi_master_fifo spi_master_fifo_properties u_props (.core_clk, .reset, .sfrAddr,
    .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .irqRequest, .master_serial_clock_pin,
    .master_out_pin, .master_in_pin);

/* File: dv/spi_slave_model.sv */
// Behavioural external SPI slave selected by a software chip select.
module spi_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsbFirst,
    input wire logic csN,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt = 0;
    logic [7:0] shiftIn = 8'h00;
    function automatic int unsigned idx(input int unsigned n);
        return lsbFirst ? n : 7 - n;
    endfunction : idx
    initial begin
        miso = 1'b1;
        rxByte = 8'h00;
    end
    // A deselected slave leaves the line, modelled as the inverse of its last bit.
    always @(csN) begin
        cnt = 0;
        miso = csN ? ~miso : txByte[idx(0)];
    end
    always @(sck) begin
        if (!csN) begin
            if ((sck != cpol) ^ cpha) begin
                shiftIn[idx(cnt)] = mosi;
                cnt++;
                if (cnt == 8) begin
                    rxByte = shiftIn;
                    cnt = 0;
                end
            end else begin
                miso = txByte[idx(cnt)];
            end
        end
    end
endmodule : spi_slave_model

/* File: dv/tb.sv */
// Self-checking bench driving the SPI master registers against a slave model.
`include "spi_master_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_master_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    byte_t sfrWdata = 8'h00;
    byte_t sfrRdata;
    byte_t cfgVal = 8'h20;
    byte_t slvTx = 8'h00;
    byte_t slvRx;
    byte_t rdv;
    logic irqRequest;
    logic sck;
    logic mosi;
    logic miso;
    logic csN = 1'b1;
    time tEdge = 0;
    time tGap = 0;
    int n_mismatch = 0;
    int n_compared = 0;

    spi_master_fifo u_dut (.core_clk(core_clk), .reset(reset), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .irqRequest(irqRequest), .master_serial_clock_pin(sck), .master_out_pin(mosi),
        .master_in_pin(miso));
    spi_slave_model u_slave (.sck(sck), .mosi(mosi), .cpol(cfgVal[`CFG_CPOL_BIT]),
        .cpha(cfgVal[`CFG_CPHA_BIT]), .lsbFirst(cfgVal[`CFG_LSB_BIT]), .csN(csN),
        .txByte(slvTx), .miso(miso), .rxByte(slvRx));

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(sck) begin
        tGap = $time - tEdge;
        tEdge = $time;
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input byte_t seen, input byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input byte_t d);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(posedge core_clk);
        #1 sfrWrite = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output byte_t d);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(posedge core_clk);
        #1 sfrRead = 1'b0;
        @(posedge core_clk);
        #1 d = sfrRdata;
    endtask : rd
    task automatic rdchk(input string what, input logic [7:0] a, input byte_t exp);
        rd(a, rdv);
        chk(what, rdv, exp);
    endtask : rdchk
    task automatic waitFlag(input int b);
        for (int i = 0; i < 400; i++) begin
            rd(`STATUS_ADDR, rdv);
            if (rdv[b] === 1'b1) return;
        end
        n_mismatch++;
        $display("BAD status wait expected flag seen none");
        close_out();
    endtask : waitFlag
    task automatic xfer(input byte_t c, input byte_t m, input byte_t s);
        csN = 1'b1;
        cfgVal = c;
        slvTx = s;
        wr(`CFG_ADDR, c & 8'hFE);
        chk("idle polarity", {7'h00, sck}, {7'h00, c[`CFG_CPOL_BIT]});
        wr(`DATA_ADDR, m);
        rdchk("held status", `STATUS_ADDR, 8'h01);
        csN = 1'b0;
        wr(`CFG_ADDR, c);
        waitFlag(`ST_RX_AVAIL);
        chk("idle clock", {7'h00, sck}, {7'h00, c[`CFG_CPOL_BIT]});
        chk("half period", byte_t'(tGap / 40), (c[6:4] > 3'h4) ? 8'h20 : 8'h01 << c[6:4]);
        chk("slave rx", slvRx, m);
        rd(`DATA_ADDR, rdv);
        if (c[6:4] > 3'h1) chk("rx byte", rdv, s);
    endtask : xfer

    initial begin
        repeat (20) @(posedge core_clk);
        #1 reset = 1'b0;
        rdchk("config", `CFG_ADDR, 8'h20);
        rdchk("mask", `MASK_ADDR, 8'h0F);
        rdchk("status", `STATUS_ADDR, 8'h03);
        rdchk("empty data", `DATA_ADDR, 8'h00);
        rdchk("unmapped", 8'h10, 8'h00);
        wr(`STATUS_ADDR, 8'h00);
        rdchk("status kept", `STATUS_ADDR, 8'h03);
        wr(`MASK_ADDR, 8'hFE);
        rdchk("mask write", `MASK_ADDR, 8'h0E);
        chk("space irq", {7'h00, irqRequest}, 8'h01);
        wr(`MASK_ADDR, 8'h0F);
        chk("masked irq", {7'h00, irqRequest}, 8'h00);
        for (int k = 0; k < 8; k++) begin
            xfer({1'b0, 2'b01, k[0], k[2:0], 1'b1}, 8'h96 ^ 8'(k), 8'h3C + 8'(k));
        end
        for (int k = 0; k < 8; k++) begin
            xfer({1'b0, 3'(k), 4'b0011}, 8'hE1, 8'h5A);
        end
        csN = 1'b1;
        cfgVal = 8'h21;
        slvTx = 8'hC3;
        wr(`CFG_ADDR, 8'h21);
        csN = 1'b0;
        wr(`DATA_ADDR, 8'h11);
        wr(`DATA_ADDR, 8'h22);
        wr(`DATA_ADDR, 8'h33);
        wr(`DATA_ADDR, 8'h44);
        waitFlag(`ST_RX_FULL);
        rdchk("full status", `STATUS_ADDR, 8'h0D);
        wr(`MASK_ADDR, 8'h07);
        chk("full irq", {7'h00, irqRequest}, 8'h01);
        rdchk("rx head", `DATA_ADDR, 8'hC3);
        chk("irq drop", {7'h00, irqRequest}, 8'h00);
        waitFlag(`ST_RX_FULL);
        chk("back to back", slvRx, 8'h33);
        rdchk("drop status", `STATUS_ADDR, 8'h0F);
        close_out();
    end
endmodule : tb
